/* src/icw_pkg.sv */
// Constants shared by the input capture window block
package icw_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ICW_HSTART_LO = 8'h00;
  localparam logic [7:0] ICW_HSTART_HI = 8'h01;
  localparam logic [7:0] ICW_VSTART_LO = 8'h02;
  localparam logic [7:0] ICW_VSTART_HI = 8'h03;
  localparam logic [7:0] ICW_WIDTH_LO = 8'h04;
  localparam logic [7:0] ICW_WIDTH_HI = 8'h05;
  localparam logic [7:0] ICW_LINES_LO = 8'h06;
  localparam logic [7:0] ICW_LINES_HI = 8'h07;
  localparam logic [7:0] ICW_SAMPLES_LO = 8'h08;
  localparam logic [7:0] ICW_SAMPLES_HI = 8'h09;
  localparam logic [7:0] ICW_LCLK_LO = 8'h0a;
  localparam logic [7:0] ICW_LCLK_HI = 8'h0b;
  localparam logic [7:0] ICW_FLINES_LO = 8'h0c;
  localparam logic [7:0] ICW_FLINES_HI = 8'h0d;

  // ----------------------------------------
  // Field widths
  // ----------------------------------------
  localparam int ICW_HSTART_W = 11;
  localparam int ICW_VSTART_W = 12;
  localparam int ICW_WIDTH_W = 10;
  localparam int ICW_LINES_W = 10;
  localparam int ICW_SAMPLES_W = 11;
  localparam int ICW_LCLK_W = 10;
  localparam int ICW_FLINES_W = 12;

  // ----------------------------------------
  // Reset values and fixed bias
  // ----------------------------------------
  localparam logic [10:0] ICW_HSTART_RST = 11'h000;
  localparam logic [11:0] ICW_VSTART_RST = 12'h000;
  localparam logic [9:0] ICW_WIDTH_RST = 10'h000;
  localparam logic [9:0] ICW_LINES_RST = 10'h000;
  localparam logic [10:0] ICW_SAMPLES_RST = 11'h000;
  localparam logic [12:0] ICW_VBIAS = 13'h0001;

endpackage

/* src/icw_pair_buf.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module icw_pair_buf
#(
  parameter int WIDTH = 26,
  parameter int DEPTH = 2
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Entries are flip-flops, but the head word reaches out_data through an rd_ptr mux
  assign out_data = mem[rd_ptr];

  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      if (push && !pop)
      begin
        count <= count + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
        count <= count - (AW+1)'(1);
      end
    end
  end

endmodule

/* src/icw_capture.sv */
// Input capture window: registers, window selection and line measurement
`timescale 1ns/100ps
//
// Contract
// [RL1] Hold 11-bit horizontal start, split three/eight
// [RL2] Start beyond line samples writes no pixels
// [RL3] Hold 12-bit vertical start, one-line bias
// [RL4] Vertical start limited by measured frame lines
// [RL5] Store exactly active width pixels per line
// [RL6] Active width at most 1023, below samples-1
// [RL7] NTSC output width budget below 894
// [RL8] PAL output width budget below 1125
// [RL9] Store programmed line count per field
// [RL10] Line count bounded by scaled measured lines
// [RL11] Line count plus offsets below 525/625
// [RL12] Hold 11-bit line sample terminal count
// [RL13] Sampling PLL divider from line sample count
// [RL14] Samples times line rate 16-50 MHz
// [RL15] Measure subcarrier clocks per line, read-only
// [RL16] Unused register bits read back zero
// [RL17] Window settings change only at frame boundary
module icw_capture
  import icw_pkg::*;
#(
  parameter int PIX_W = 24,
  parameter int BUF_DEPTH = 2
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Incoming video
  input wire logic hsync,
  input wire logic vsync,
  input wire logic pix_valid,
  input wire logic [PIX_W-1:0] pix_data,
  output logic pix_ready,
  input wire logic fsc_tick,
  // Sampling clock PLL
  output logic [ICW_SAMPLES_W-1:0] pll_divider,
  // Frame store writer
  output logic fs_valid,
  input wire logic fs_ready,
  output logic [PIX_W-1:0] fs_data,
  output logic fs_line_start,
  output logic fs_frame_start
);

  // ----------------------------------------
  // Programmed settings
  // ----------------------------------------
  logic [ICW_HSTART_W-1:0] capture_hstart;
  logic [ICW_VSTART_W-1:0] capture_vstart;
  logic [ICW_WIDTH_W-1:0] active_width;
  logic [ICW_LINES_W-1:0] stored_lines;
  logic [ICW_SAMPLES_W-1:0] line_samples;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      capture_hstart <= ICW_HSTART_RST;
      capture_vstart <= ICW_VSTART_RST;
      active_width <= ICW_WIDTH_RST;
      stored_lines <= ICW_LINES_RST;
      line_samples <= ICW_SAMPLES_RST;
    end
    else if (reg_write)
    begin
      if (reg_addr == ICW_HSTART_LO)
        capture_hstart[7:0] <= reg_wdata; // [RL1]
      else if (reg_addr == ICW_HSTART_HI)
        capture_hstart[10:8] <= reg_wdata[2:0]; // [RL1]
      else if (reg_addr == ICW_VSTART_LO)
        capture_vstart[7:0] <= reg_wdata; // [RL3]
      else if (reg_addr == ICW_VSTART_HI)
        capture_vstart[11:8] <= reg_wdata[3:0]; // [RL3]
      else if (reg_addr == ICW_WIDTH_LO)
        active_width[7:0] <= reg_wdata; // [RL5]
      else if (reg_addr == ICW_WIDTH_HI)
        active_width[9:8] <= reg_wdata[1:0]; // [RL5]
      else if (reg_addr == ICW_LINES_LO)
        stored_lines[7:0] <= reg_wdata; // [RL9]
      else if (reg_addr == ICW_LINES_HI)
        stored_lines[9:8] <= reg_wdata[1:0]; // [RL9]
      else if (reg_addr == ICW_SAMPLES_LO)
        line_samples[7:0] <= reg_wdata; // [RL12]
      else if (reg_addr == ICW_SAMPLES_HI)
        line_samples[10:8] <= reg_wdata[2:0]; // [RL12]
    end
  end

  // PLL is retuned at once; holding it to a frame edge gains nothing
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      pll_divider <= ICW_SAMPLES_RST;
    else
      pll_divider <= line_samples; // [RL13]
  end

  // ----------------------------------------
  // Sync edges
  // ----------------------------------------
  logic hsync_d;
  logic vsync_d;
  logic h_lead;
  logic v_lead;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      hsync_d <= 1'b0;
      vsync_d <= 1'b0;
    end
    else
    begin
      hsync_d <= hsync;
      vsync_d <= vsync;
    end
  end

  assign h_lead = hsync && !hsync_d;
  assign v_lead = vsync && !vsync_d;

  // ----------------------------------------
  // Frame-boundary shadows
  // ----------------------------------------
  logic [ICW_HSTART_W-1:0] act_hstart;
  logic [ICW_VSTART_W-1:0] act_vstart;
  logic [ICW_WIDTH_W-1:0] act_width;
  logic [ICW_LINES_W-1:0] act_lines;
  logic [ICW_SAMPLES_W-1:0] act_samples;

  // A frame in progress keeps its window even if software rewrites it
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      act_hstart <= ICW_HSTART_RST;
      act_vstart <= ICW_VSTART_RST;
      act_width <= ICW_WIDTH_RST;
      act_lines <= ICW_LINES_RST;
      act_samples <= ICW_SAMPLES_RST;
    end
    else if (v_lead)
    begin
      act_hstart <= capture_hstart; // [RL17]
      act_vstart <= capture_vstart; // [RL17]
      act_width <= active_width; // [RL17]
      act_lines <= stored_lines; // [RL17]
      act_samples <= line_samples; // [RL17]
    end
  end

  // ----------------------------------------
  // Position counters
  // ----------------------------------------
  logic [ICW_SAMPLES_W-1:0] pix_cnt;
  logic [ICW_FLINES_W-1:0] line_cnt;
  logic pix_sat;
  logic line_sat;

  assign pix_sat = (pix_cnt == '1);
  assign line_sat = (line_cnt == '1);

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      pix_cnt <= '0;
    else if (h_lead)
      pix_cnt <= '0;
    else if (pix_valid && pix_ready && !pix_sat)
      pix_cnt <= pix_cnt + ICW_SAMPLES_W'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      line_cnt <= '0;
    else if (v_lead)
      line_cnt <= '0;
    else if (h_lead && !line_sat)
      line_cnt <= line_cnt + ICW_FLINES_W'(1);
  end

  // ----------------------------------------
  // Window selection
  // ----------------------------------------
  logic [12:0] v_first;
  logic [12:0] v_end;
  logic [11:0] h_end;
  logic in_rows;
  logic in_cols;
  logic h_legal;
  logic take;
  logic first_row;
  logic first_col;

  assign v_first = {1'b0, act_vstart} + ICW_VBIAS; // [RL3]
  assign v_end = v_first + {3'b000, act_lines}; // [RL9]
  assign in_rows = ({1'b0, line_cnt} >= v_first)
    && ({1'b0, line_cnt} < v_end); // [RL9]
  assign h_end = {1'b0, act_hstart} + {2'b00, act_width}; // [RL5]
  assign in_cols = ({1'b0, pix_cnt} >= {1'b0, act_hstart})
    && ({1'b0, pix_cnt} < h_end); // [RL5]
  // An illegal start beyond the line's samples suppresses all writes
  assign h_legal = (act_hstart <= act_samples); // [RL2]
  assign take = pix_valid && in_rows && in_cols && h_legal;
  assign first_row = ({1'b0, line_cnt} == v_first);
  assign first_col = (pix_cnt == act_hstart);

  // ----------------------------------------
  // Frame store path
  // ----------------------------------------
  logic buf_ready;
  logic [PIX_W+1:0] buf_out;

  // Back-pressure is offered to the source only inside the window
  assign pix_ready = !take || buf_ready;

  icw_pair_buf #(
    .WIDTH(PIX_W + 2),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_valid(take),
    .in_ready(buf_ready),
    .in_data({first_row && first_col, first_col, pix_data}),
    .out_valid(fs_valid),
    .out_ready(fs_ready),
    .out_data(buf_out)
  );

  assign fs_data = buf_out[PIX_W-1:0];
  assign fs_line_start = buf_out[PIX_W];
  assign fs_frame_start = buf_out[PIX_W+1];

  // ----------------------------------------
  // Line and frame measurement
  // ----------------------------------------
  logic [ICW_LCLK_W-1:0] fsc_cnt;
  logic [ICW_LCLK_W-1:0] measured_line_clocks;
  logic [ICW_FLINES_W-1:0] measured_frame_lines;

  // Counts saturate so a lost sync reads as the top value, not a wrap
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      fsc_cnt <= '0;
      measured_line_clocks <= '0;
    end
    else if (h_lead)
    begin
      measured_line_clocks <= fsc_cnt; // [RL15]
      fsc_cnt <= fsc_tick ? ICW_LCLK_W'(1) : '0;
    end
    else if (fsc_tick && fsc_cnt != '1)
    begin
      fsc_cnt <= fsc_cnt + ICW_LCLK_W'(1); // [RL15]
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      measured_frame_lines <= '0;
    else if (v_lead)
      measured_frame_lines <= line_cnt; // [RL4]
  end

  // ----------------------------------------
  // Register read-back
  // ----------------------------------------
  logic [7:0] next_rdata;

  always_comb
  begin
    next_rdata = 8'h00; // [RL16]
    if (reg_addr == ICW_HSTART_LO)
      next_rdata = capture_hstart[7:0];
    else if (reg_addr == ICW_HSTART_HI)
      next_rdata = {5'h00, capture_hstart[10:8]}; // [RL16]
    else if (reg_addr == ICW_VSTART_LO)
      next_rdata = capture_vstart[7:0];
    else if (reg_addr == ICW_VSTART_HI)
      next_rdata = {4'h0, capture_vstart[11:8]}; // [RL16]
    else if (reg_addr == ICW_WIDTH_LO)
      next_rdata = active_width[7:0];
    else if (reg_addr == ICW_WIDTH_HI)
      next_rdata = {6'h00, active_width[9:8]}; // [RL16]
    else if (reg_addr == ICW_LINES_LO)
      next_rdata = stored_lines[7:0];
    else if (reg_addr == ICW_LINES_HI)
      next_rdata = {6'h00, stored_lines[9:8]}; // [RL16]
    else if (reg_addr == ICW_SAMPLES_LO)
      next_rdata = line_samples[7:0];
    else if (reg_addr == ICW_SAMPLES_HI)
      next_rdata = {5'h00, line_samples[10:8]}; // [RL16]
    else if (reg_addr == ICW_LCLK_LO)
      next_rdata = measured_line_clocks[7:0]; // [RL15]
    else if (reg_addr == ICW_LCLK_HI)
      next_rdata = {6'h00, measured_line_clocks[9:8]}; // [RL15]
    else if (reg_addr == ICW_FLINES_LO)
      next_rdata = measured_frame_lines[7:0]; // [RL4]
    else if (reg_addr == ICW_FLINES_HI)
      next_rdata = {4'h0, measured_frame_lines[11:8]}; // [RL4]
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_read)
      reg_rdata <= next_rdata;
  end

endmodule

/* test/icw_capture_properties.sv */
// Port-level checks for the input capture window block
`timescale 1ns/100ps
module icw_capture_properties
  import icw_pkg::*;
#(
  parameter int PIX_W = 24
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Outputs
  input wire logic [ICW_SAMPLES_W-1:0] pll_divider,
  input wire logic fs_valid,
  input wire logic fs_ready,
  input wire logic [PIX_W-1:0] fs_data,
  input wire logic fs_line_start
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // ----
  // Readback
  // ----
  sequence wr_then_rd(logic [7:0] a);
    reg_write && reg_addr == a ##1 reg_read && reg_addr == a && !reg_write;
  endsequence
  property readback(logic [7:0] a);
    wr_then_rd(a) |=> reg_rdata == $past(reg_wdata, 2);
  endproperty

  hstart_rb_a: assert property (readback(ICW_HSTART_LO))
    else $error("hstart readback wrong");
  vstart_rb_a: assert property (readback(ICW_VSTART_LO))
    else $error("vstart readback wrong");
  width_rb_a: assert property (readback(ICW_WIDTH_LO))
    else $error("width readback wrong");
  lines_rb_a: assert property (readback(ICW_LINES_LO))
    else $error("lines readback wrong");
  width_hi_zero_a: assert property (
    reg_read && reg_addr == ICW_WIDTH_HI |=> reg_rdata[7:2] == 6'h00)
    else $error("width high unused bits set");
  hstart_hi_zero_a: assert property (
    reg_read && reg_addr == ICW_HSTART_HI |=> reg_rdata[7:3] == 5'h00)
    else $error("hstart high unused bits set");
  unmapped_zero_a: assert property (
    reg_read && reg_addr > ICW_FLINES_HI |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // ----
  // Divider and output hold
  // ----
  pll_low_a: assert property (
    reg_write && reg_addr == ICW_SAMPLES_LO
    |-> ##2 pll_divider[7:0] == $past(reg_wdata, 2))
    else $error("divider low byte not loaded");
  pll_high_a: assert property (
    reg_write && reg_addr == ICW_SAMPLES_HI
    |-> ##2 {5'h00, pll_divider[10:8]} == ($past(reg_wdata, 2) & 8'h07))
    else $error("divider high bits not loaded");
  stall_hold_a: assert property (
    fs_valid && !fs_ready
    |=> fs_valid && $stable(fs_data) && $stable(fs_line_start))
    else $error("stored word lost under stall");
endmodule

bind icw_capture icw_capture_properties #(.PIX_W(PIX_W)) chk (
  .ref_clk, .reset, .reg_addr, .reg_write, .reg_wdata, .reg_read,
  .reg_rdata, .pll_divider, .fs_valid, .fs_ready, .fs_data, .fs_line_start
);

/* test/icw_video_src.sv */
// Behavioural video source: syncs, samples and reference ticks
`timescale 1ns/100ps
module icw_video_src
(
  // Clock and flow control
  input wire logic ref_clk,
  input wire logic pix_ready,
  // Video out
  output logic hsync,
  output logic vsync,
  output logic pix_valid,
  output logic [23:0] pix_data,
  output logic fsc_tick
);
  logic [7:0] ln;

  initial
  begin
    hsync = 1'b0;
    vsync = 1'b0;
    pix_valid = 1'b0;
    pix_data = 24'h000000;
    fsc_tick = 1'b0;
    ln = 8'h00;
  end

  task automatic vs();
    vsync <= 1'b1;
    ln = 8'h00;
    @(posedge ref_clk);
    vsync <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Samples carry line and position so the stored words can be predicted
  task automatic line(input int n);
    logic r;
    hsync <= 1'b1;
    ln = ln + 8'h01;
    @(posedge ref_clk);
    hsync <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      pix_valid <= 1'b1;
      pix_data <= {8'h00, ln, 8'(i)};
      do
      begin
        @(negedge ref_clk);
        r = pix_ready;
        @(posedge ref_clk);
      end
      while (!r);
    end
    // Released data is inverted so a stale word cannot pass for a match
    pix_valid <= 1'b0;
    pix_data <= ~pix_data;
    @(posedge ref_clk);
  endtask

  task automatic ticks(input int k);
    repeat (k)
    begin
      fsc_tick <= 1'b1;
      @(posedge ref_clk);
    end
    fsc_tick <= 1'b0;
    @(posedge ref_clk);
  endtask
endmodule

/* test/input_capture_window_test.sv */
// Self-checking bench for the input capture window block
`timescale 1ns/100ps
module input_capture_window_test
  import icw_pkg::*;
;
  logic ref_clk, reset, reg_write, reg_read, fs_ready, stall, seen_full;
  logic hsync, vsync, pix_valid, pix_ready, fsc_tick, fs_valid;
  logic fs_line_start, fs_frame_start;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic [23:0] pix_data, fs_data;
  logic [10:0] pll_divider;
  logic [25:0] q[$];
  int err_count, tests_run, cyc;

  icw_capture dut (.ref_clk, .reset, .reg_addr, .reg_write, .reg_wdata,
    .reg_read, .reg_rdata, .hsync, .vsync, .pix_valid, .pix_data,
    .pix_ready, .fsc_tick, .pll_divider, .fs_valid, .fs_ready, .fs_data,
    .fs_line_start, .fs_frame_start);
  icw_video_src src (.ref_clk, .pix_ready, .hsync, .vsync, .pix_valid,
    .pix_data, .fsc_tick);

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----
  // Receiver, collector and watchdog
  // ----
  // A stalled receiver takes one word in four so the buffer must refuse
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    fs_ready <= !stall || cyc[1:0] == 2'b00;
    if (cyc == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end

  always @(negedge ref_clk)
  begin
    if (fs_valid && fs_ready)
      q.push_back({fs_frame_start, fs_line_start, fs_data});
    if (pix_valid && !pix_ready)
      seen_full = 1'b1;
  end

  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Write, then read the same place back into rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(negedge ref_clk);
    rd = reg_rdata;
    @(posedge ref_clk);
  endtask

  task automatic rdr(input logic [7:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(negedge ref_clk);
    rd = reg_rdata;
    @(posedge ref_clk);
  endtask

  task automatic cfg(input logic [11:0] hs, vs, w, nl, sm);
    logic [11:0] v[5];
    v = '{hs, vs, w, nl, sm};
    for (int i = 0; i < 5; i++)
    begin
      wr(8'(2 * i), v[i][7:0]);
      wr(8'(2 * i + 1), {4'h0, v[i][11:8]});
    end
  endtask

  task automatic frame(input int nl, input int np);
    src.vs();
    repeat (nl) src.line(np);
    repeat (16) @(posedge ref_clk);
  endtask

  task automatic expect_win(input int l0, nl, h0, w);
    int k;
    k = 0;
    chk(q.size(), nl * w);
    for (int l = 0; l < nl; l++)
      for (int p = 0; p < w; p++)
      begin
        chk(q[k], {l == 0 && p == 0, p == 0, 8'h00, 8'(l0 + l), 8'(h0 + p)});
        k++;
      end
    q.delete();
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    logic [7:0] m[10];
    m = '{8'hff, 8'h07, 8'hff, 8'h0f, 8'hff, 8'h03, 8'hff, 8'h03, 8'hff,
      8'h07};
    for (int i = 0; i < 10; i++)
    begin
      rdr(8'(i));
      chk(rd, 32'h0);
      wr(8'(i), 8'hff);
      chk(rd, m[i]);
    end
    @(negedge ref_clk);
    chk(pll_divider, 11'h7ff);
    @(posedge ref_clk);
    wr(8'h20, 8'h5a);
    chk(rd, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_window();
    cfg(12'h002, 12'h001, 12'h003, 12'h002, 12'h064);
    stall <= 1'b1;
    frame(5, 8);
    stall <= 1'b0;
    expect_win(2, 2, 2, 3);
    chk(seen_full, 1'b1);
    $display("t_window done");
  endtask

  // A width change in mid-frame must wait for the next frame
  task automatic t_edge();
    src.vs();
    repeat (2) src.line(8);
    wr(ICW_WIDTH_LO, 8'h01);
    repeat (3) src.line(8);
    repeat (16) @(posedge ref_clk);
    expect_win(2, 2, 2, 3);
    frame(5, 8);
    expect_win(2, 2, 2, 1);
    $display("t_edge done");
  endtask

  task automatic t_hstart();
    cfg(12'h00a, 12'h000, 12'h002, 12'h001, 12'h005);
    frame(3, 12);
    chk(q.size(), 32'h0);
    q.delete();
    cfg(12'h101, 12'h000, 12'h002, 12'h001, 12'h200);
    frame(2, 260);
    expect_win(1, 1, 257, 2);
    $display("t_hstart done");
  endtask

  task automatic t_meas();
    src.line(0);
    src.ticks(5);
    src.line(0);
    rdr(ICW_LCLK_LO);
    chk(rd, 32'h5);
    wr(ICW_LCLK_LO, 8'h00);
    chk(rd, 32'h5);
    rdr(ICW_LCLK_HI);
    chk(rd, 32'h0);
    // Three empty lines between two frame edges give a known line count
    src.vs();
    repeat (3) src.line(0);
    src.vs();
    rdr(ICW_FLINES_LO);
    chk(rd, 32'h3);
    rdr(ICW_FLINES_HI);
    chk(rd, 32'h0);
    $display("t_meas done");
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    reset = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    fs_ready = 1'b1;
    stall = 1'b0;
    seen_full = 1'b0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_window();
    t_edge();
    t_hstart();
    t_meas();
    print_verdict();
  end
endmodule
